// ==== rio_pkg.sv ====
package rio_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_STD_NS  = 19_200_000;  // standard delay, typical
  localparam int FRAME_HS_NS   = 3_000_000;   // high speed delay, typical
  localparam int FRAME_STD_CYC = FRAME_STD_NS / CLK_PERIOD_NS;
  localparam int FRAME_HS_CYC  = FRAME_HS_NS / CLK_PERIOD_NS;
  localparam int SLOTS         = 20;          // start, 16 data, parity, two stop
  localparam int TMO_FRAMES    = 3;           // frames without a good one
  localparam int CW            = 24;          // width of cycle counters

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0]  SLOT_START = 5'h00;
  localparam logic [4:0]  SLOT_LAST  = 5'h13;
  localparam logic [4:0]  PTS_8      = 5'h08;
  localparam logic [4:0]  PTS_16     = 5'h10;
  localparam logic [15:0] MASK_8     = 16'h00FF;
  localparam logic [15:0] MASK_16    = 16'hFFFF;
  localparam logic [1:0]  CFG_SETTLE = 2'h3;  // cycles before straps are taken
  localparam int          FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [15:0] rio_word_t;

  typedef struct packed {
    logic error_handling_select;  // 1 clear, 0 hold
    logic speed_select;           // 1 high speed, 0 standard
    logic error_lamp_enable;      // 1 orange lamp may light
    logic eight_points;           // 1 eight points, 0 sixteen
  } rio_cfg_t;

  typedef struct packed {
    logic green;
    logic orange;
  } rio_lamp_t;

  typedef enum {RIO_RX_IDLE, RIO_RX_BITS} rio_rx_state_t;

endpackage

// ==== rio_link.sv ====
// Overview of operation
// - move up to sixteen input and output points; eight or sixteen per direction
// - on link error clear inputs when clear selected, else hold last good
// - speed select picks high speed 3 ms or standard 19.2 ms frames
// - lamp green when normal, orange on error only if lamp enabled
// - one direction per line, time shared serial frame of all points
`timescale 1ns/1ps

// ------------------------------------------------------------------
// output word buffer
// ------------------------------------------------------------------
module rio_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // fill side
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  // drain side
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic             push, pop;

  // extra pointer bit tells full from empty
  always_comb begin
    wr_ready = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
    rd_valid = (wp_q != rp_q);
    rd_data  = mem[rp_q[AW-1:0]];
    push     = wr_valid && wr_ready;
    pop      = rd_valid && rd_ready;
    wp_d     = push ? wp_q + 1'b1 : wp_q;
    rp_d     = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage needs no reset
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= wr_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// remote point link
// ------------------------------------------------------------------
module rio_link #(
  parameter int FRAME_STD = rio_pkg::FRAME_STD_CYC,
  parameter int FRAME_HS  = rio_pkg::FRAME_HS_CYC
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // configuration straps
  input  wire rio_pkg::rio_cfg_t cfg_pins,
  // serial lines
  input  wire logic              rx_line,
  output logic                   tx_line,
  // output points from user
  input  wire rio_pkg::rio_word_t out_data,
  input  wire logic              out_valid,
  output logic                   out_ready,
  // input points to user
  output rio_pkg::rio_word_t     in_points,
  output logic                   in_update,
  output logic                   link_error,
  output rio_pkg::rio_lamp_t     lamp
);
  import rio_pkg::*;

  localparam logic [CW-1:0] BIT_STD = CW'(FRAME_STD / SLOTS);
  localparam logic [CW-1:0] BIT_HS  = CW'(FRAME_HS / SLOTS);
  localparam logic [CW-1:0] TMO_STD = CW'(FRAME_STD * TMO_FRAMES);
  localparam logic [CW-1:0] TMO_HS  = CW'(FRAME_HS * TMO_FRAMES);

  // ----------------------------------------------------------------
  // synchronisers and strap capture
  // ----------------------------------------------------------------
  logic [3:0]    cfg_s1_q, cfg_s2_q;
  logic          rx_s1_q, rx_s2_q, rx_s3_q;
  rio_cfg_t      cfg_q, cfg_d;
  logic          cfg_done_q, cfg_done_d;
  logic [1:0]    settle_q, settle_d;
  logic [CW-1:0] bit_cyc, tmo_cyc;
  logic [4:0]    n_pts;
  logic [15:0]   pt_mask;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
      rx_s1_q  <= 1'b1;
      rx_s2_q  <= 1'b1;
      rx_s3_q  <= 1'b1;
    end else begin
      cfg_s1_q <= cfg_pins;
      cfg_s2_q <= cfg_s1_q;
      rx_s1_q  <= rx_line;
      rx_s2_q  <= rx_s1_q;
      rx_s3_q  <= rx_s2_q;
    end
  end

  // straps taken once after release; changing them needs a reset
  always_comb begin
    cfg_d      = cfg_q;
    cfg_done_d = cfg_done_q;
    settle_d   = settle_q;
    if (!cfg_done_q) begin
      if (settle_q == CFG_SETTLE) begin
        cfg_d      = rio_cfg_t'(cfg_s2_q);
        cfg_done_d = 1'b1;
      end else begin
        settle_d = settle_q + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_q      <= '0;
      cfg_done_q <= 1'b0;
      settle_q   <= '0;
    end else begin
      cfg_q      <= cfg_d;
      cfg_done_q <= cfg_done_d;
      settle_q   <= settle_d;
    end
  end

  // speed and width follow the captured straps
  always_comb begin
    bit_cyc = cfg_q.speed_select ? BIT_HS : BIT_STD;
    tmo_cyc = cfg_q.speed_select ? TMO_HS : TMO_STD;
    n_pts   = cfg_q.eight_points ? PTS_8 : PTS_16;
    pt_mask = cfg_q.eight_points ? MASK_8 : MASK_16;
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  rio_word_t fifo_data;
  logic      fifo_valid, fifo_take;
  rio_word_t tx_word_q, tx_word_d;
  logic [CW-1:0] tx_cnt_q, tx_cnt_d;
  logic [4:0]    tx_slot_q, tx_slot_d;
  logic          tx_line_q, tx_line_d;

  rio_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk     (mclk),
    .resetn   (resetn),
    .wr_data  (out_data),
    .wr_valid (out_valid),
    .wr_ready (out_ready),
    .rd_data  (fifo_data),
    .rd_valid (fifo_valid),
    .rd_ready (fifo_take)
  );

  // frames run back to back; with no new word the last one is resent
  always_comb begin
    tx_cnt_d  = tx_cnt_q;
    tx_slot_d = tx_slot_q;
    tx_word_d = tx_word_q;
    tx_line_d = tx_line_q;
    fifo_take = 1'b0;
    if (cfg_done_q) begin
      if (tx_cnt_q == '0) begin
        tx_cnt_d  = bit_cyc - CW'(1);
        tx_slot_d = (tx_slot_q == SLOT_LAST) ? SLOT_START : tx_slot_q + 5'h01;
        if (tx_slot_d == SLOT_START) begin
          fifo_take = 1'b1;
          if (fifo_valid) begin
            tx_word_d = fifo_data & pt_mask;
          end
        end
        if (tx_slot_d == SLOT_START) begin
          tx_line_d = 1'b0;
        end else if (tx_slot_d <= n_pts) begin
          tx_line_d = tx_word_d[4'(tx_slot_d - 5'h01)];
        end else if (tx_slot_d == n_pts + 5'h01) begin
          tx_line_d = ^tx_word_d;
        end else begin
          tx_line_d = 1'b1;
        end
      end else begin
        tx_cnt_d = tx_cnt_q - CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_cnt_q  <= '0;
      tx_slot_q <= SLOT_LAST;
      tx_word_q <= '0;
      tx_line_q <= 1'b1;
    end else begin
      tx_cnt_q  <= tx_cnt_d;
      tx_slot_q <= tx_slot_d;
      tx_word_q <= tx_word_d;
      tx_line_q <= tx_line_d;
    end
  end

  assign tx_line = tx_line_q;

  // ----------------------------------------------------------------
  // receiver and error handling
  // ----------------------------------------------------------------
  rio_rx_state_t rx_st_q, rx_st_d;
  logic [CW-1:0] rx_cnt_q, rx_cnt_d, wdog_q, wdog_d;
  logic [4:0]    rx_slot_q, rx_slot_d;
  rio_word_t     rx_word_q, rx_word_d, pts_q, pts_d;
  logic          par_q, par_d, ev_good, ev_bad, ev_tmo, ev_err;
  logic          err_q, err_d, upd_q, upd_d;
  rio_lamp_t     lamp_q, lamp_d;

  // sample mid-bit; remote inputs must outlast a frame to be seen
  always_comb begin
    rx_st_d   = rx_st_q;
    rx_cnt_d  = rx_cnt_q;
    rx_slot_d = rx_slot_q;
    rx_word_d = rx_word_q;
    par_d     = par_q;
    ev_good   = 1'b0;
    ev_bad    = 1'b0;
    case (rx_st_q)
      RIO_RX_IDLE: begin
        if (cfg_done_q && rx_s3_q && !rx_s2_q) begin
          rx_st_d   = RIO_RX_BITS;
          rx_cnt_d  = bit_cyc >> 1;
          rx_slot_d = SLOT_START;
          rx_word_d = '0;
        end
      end
      default: begin
        if (rx_cnt_q != '0) begin
          rx_cnt_d = rx_cnt_q - CW'(1);
        end else begin
          rx_cnt_d  = bit_cyc - CW'(1);
          rx_slot_d = rx_slot_q + 5'h01;
          if (rx_slot_q == SLOT_START) begin
            if (rx_s2_q) begin
              rx_st_d = RIO_RX_IDLE;  // glitch, not a start
            end
          end else if (rx_slot_q <= n_pts) begin
            rx_word_d[4'(rx_slot_q - 5'h01)] = rx_s2_q;
          end else if (rx_slot_q == n_pts + 5'h01) begin
            par_d = rx_s2_q;
          end else begin
            rx_st_d = RIO_RX_IDLE;
            ev_good = rx_s2_q && (par_q == ^rx_word_q);
            ev_bad  = !ev_good;
          end
        end
      end
    endcase
  end

  // a silent link is an error too, after a few frame times
  always_comb begin
    ev_tmo = 1'b0;
    wdog_d = wdog_q;
    if (ev_good || !cfg_done_q) begin
      wdog_d = '0;
    end else if (wdog_q == tmo_cyc) begin
      ev_tmo = 1'b1;
      wdog_d = '0;
    end else begin
      wdog_d = wdog_q + CW'(1);
    end
    ev_err = ev_bad || ev_tmo;
    err_d  = ev_good ? 1'b0 : (ev_err ? 1'b1 : err_q);
    upd_d  = ev_good;
    pts_d  = pts_q;
    if (ev_good) begin
      pts_d = rx_word_q & pt_mask;
    end else if (ev_err && cfg_q.error_handling_select) begin
      pts_d = '0;
    end
    lamp_d.green  = cfg_done_q && !err_d;
    lamp_d.orange = err_d && cfg_q.error_lamp_enable;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_st_q   <= RIO_RX_IDLE;
      rx_cnt_q  <= '0;
      rx_slot_q <= SLOT_START;
      rx_word_q <= '0;
      par_q     <= 1'b0;
      wdog_q    <= '0;
      err_q     <= 1'b0;
      upd_q     <= 1'b0;
      pts_q     <= '0;
      lamp_q    <= '0;
    end else begin
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_slot_q <= rx_slot_d;
      rx_word_q <= rx_word_d;
      par_q     <= par_d;
      wdog_q    <= wdog_d;
      err_q     <= err_d;
      upd_q     <= upd_d;
      pts_q     <= pts_d;
      lamp_q    <= lamp_d;
    end
  end

  assign in_points  = pts_q;
  assign in_update  = upd_q;
  assign link_error = err_q;
  assign lamp       = lamp_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_eight_width: assert property (cfg_q.eight_points && upd_q |-> pts_q[15:8] == '0)
    else $error("upper points set in eight point mode");
  a_clear_on_err: assert property (ev_err && cfg_q.error_handling_select |=> pts_q == '0)
    else $error("points not cleared after link error");
  a_hold_on_err: assert property (ev_err && !cfg_q.error_handling_select |=> $stable(pts_q))
    else $error("points changed while holding on error");
  a_bit_period: assert property ($changed(tx_slot_q) && cfg_done_q |-> $past(tx_cnt_q) == '0)
    else $error("slot advanced before bit time ended");
  a_lamp_state: assert property (lamp_q.orange |-> err_q && !lamp_q.green && cfg_q.error_lamp_enable)
    else $error("orange lamp without enabled error");
  a_start_low: assert property ($changed(tx_slot_q) && tx_slot_q == SLOT_START |-> !tx_line_q)
    else $error("frame did not open with a low start slot");
  a_cfg_static: assert property (cfg_done_q |=> $stable(cfg_q) && cfg_done_q)
    else $error("configuration changed during operation");

  c_good_frame: cover property (upd_q);
  c_error:      cover property ($rose(err_q));
  c_recover:    cover property (err_q ##1 !err_q);
  c_fifo_full:  cover property (!out_ready);
endmodule

// ==== rio_remote.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// remote point unit: input frames out, output frames decoded
// ----------------------------------------------------------------
module rio_remote (
  // clock
  input  wire logic         mclk,
  // serial lines
  input  wire logic         tx_line,
  output logic              rx_line,
  // frame shape chosen by the bench
  input  wire logic [7:0]   bit_cyc,
  input  wire logic [4:0]   npts,
  // last decoded output frame
  output rio_pkg::rio_word_t tx_word,
  output logic              tx_ok,
  output logic              tx_stb
);
  import rio_pkg::*;

  initial rx_line = 1'b1;

  // one input frame; each level is held for a whole slot, never shorter
  task automatic send(input rio_word_t w, input logic bad_par);
    logic [SLOTS-1:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int k = 0; k < npts; k++) f[k+1] = w[k];
    f[npts+1] = (^(w & ((16'h1 << npts) - 16'h1))) ^ bad_par;
    for (int s = 0; s < SLOTS; s++) begin
      repeat (bit_cyc) @(posedge mclk) rx_line <= f[s];
    end
  endtask

  // decode output frames at mid slot; stop slots stay high so the next start shows
  initial begin
    tx_stb = 1'b0;
    tx_word = '0;
    tx_ok = 1'b0;
    forever begin
      do @(posedge mclk); while (tx_line !== 1'b0);
      repeat (bit_cyc / 2) @(posedge mclk);
      tx_word = '0;
      for (int k = 0; k < npts; k++) begin
        repeat (bit_cyc) @(posedge mclk);
        tx_word[k] = tx_line;
      end
      repeat (bit_cyc) @(posedge mclk);
      tx_ok = (tx_line === ^tx_word);
      repeat (bit_cyc) @(posedge mclk);
      tx_ok = tx_ok & (tx_line === 1'b1);
      tx_stb = 1'b1;
      @(posedge mclk);
      tx_stb = 1'b0;
    end
  end
endmodule

// ==== rio_link_bench.sv ====
`timescale 1ns/1ps
module rio_link_bench;
  import rio_pkg::*;
  // short frames keep the run brief: bit time 20 and 10 cycles
  localparam int FS = 400;
  localparam int FH = 200;

  rio_cfg_t   cfg_pins;
  rio_word_t  out_data, in_points, tx_word, w;
  rio_lamp_t  lamp;
  logic       mclk, resetn, rx_line, tx_line, out_valid, out_ready;
  logic       in_update, link_error, tx_ok, tx_stb;
  logic [7:0] bit_cyc;
  logic [4:0] npts;
  int         n_mismatch, check_count;
  rio_word_t  exp_in[$], exp_tx[$];

  rio_link #(.FRAME_STD(FS), .FRAME_HS(FH)) u_rio_link (
    .mclk(mclk), .resetn(resetn), .cfg_pins(cfg_pins), .rx_line(rx_line),
    .tx_line(tx_line), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .in_points(in_points), .in_update(in_update),
    .link_error(link_error), .lamp(lamp));

  rio_remote u_rio_remote (
    .mclk(mclk), .tx_line(tx_line), .rx_line(rx_line), .bit_cyc(bit_cyc),
    .npts(npts), .tx_word(tx_word), .tx_ok(tx_ok), .tx_stb(tx_stb));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // straps must already stand when reset lets go
  task automatic do_reset(input rio_cfg_t c, input logic [7:0] bc, input logic [4:0] np);
    resetn <= 1'b0;
    cfg_pins <= c;
    bit_cyc <= bc;
    npts <= np;
    repeat (5) @(posedge mclk);
    check("tx_idle", {15'h0, tx_line}, 16'h0001);
    check("in_reset", in_points, 16'h0000);
    check("lamp_reset", {13'h0, link_error, lamp}, 16'h0000);
    resetn <= 1'b1;
    repeat (20) @(posedge mclk);
  endtask

  // eight point frames carry only the low byte, so only that is noted
  task automatic push(input rio_word_t v);
    out_data <= v;
    out_valid <= 1'b1;
    do @(posedge mclk); while (out_ready !== 1'b1);
    exp_tx.push_back(v & ((npts == PTS_8) ? MASK_8 : MASK_16));
  endtask

  task automatic bad_frame(input rio_word_t pts, input rio_lamp_t lp);
    u_rio_remote.send(16'hA5C3, 1'b1);
    for (int i = 0; i < 100 && link_error !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
    check("link_error", {15'h0, link_error}, 16'h0001);
    check("pts_on_error", in_points, pts);
    check("lamp_error", {14'h0, lamp}, {14'h0, lp});
  endtask

  // each loaded input word is matched against the oldest note
  always @(posedge mclk) begin
    if (in_update === 1'b1) begin
      if (exp_in.size() == 0)
        check("stray_update", 16'h0001, 16'h0000);
      else
        check("in_points", in_points, exp_in.pop_front());
      check("err_cleared", {15'h0, link_error}, 16'h0000);
      check("lamp_green", {14'h0, lamp}, 16'h0002);
    end
  end

  // each decoded output frame against the oldest note; later repeats are not noted
  always @(posedge tx_stb) begin
    if (exp_tx.size() > 0) begin
      check("tx_word", tx_word, exp_tx.pop_front());
      check("tx_frame", {15'h0, tx_ok}, 16'h0001);
    end
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // the tests need under 6k cycles; 20k means something hangs
  initial begin
    #200_000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    cfg_pins = '0;
    out_data = '0;
    out_valid = 1'b0;
    bit_cyc = 8'(FS / 20);
    npts = 5'h10;
    n_mismatch = 0;
    check_count = 0;
    w = 16'($urandom(32'h60EE));
    // hold on error, standard speed, sixteen points, lamp enabled
    do_reset(4'b0010, 8'(FS / 20), 5'h10);
    exp_tx.push_back(16'h0000);  // empty buffer repeats the reset word
    for (int i = 0; i < FIFO_DEPTH; i++) push(16'($urandom));
    @(posedge mclk);
    check("fifo_full", {15'h0, out_ready}, 16'h0000);
    push(16'($urandom));  // waits until a frame frees a slot
    out_valid <= 1'b0;
    for (int i = 0; i < 6000 && exp_tx.size() > 0; i++) @(posedge mclk);
    check("tx_all_sent", 16'(exp_tx.size()), 16'h0000);
    $display("test output frames done");
    // straps move after capture; the device must keep the first set
    cfg_pins <= 4'b1101;
    w = 16'($urandom);
    exp_in.push_back(w);
    u_rio_remote.send(w, 1'b0);
    repeat (5) @(posedge mclk);
    check("in_taken", 16'(exp_in.size()), 16'h0000);
    bad_frame(w, 2'b01);
    $display("test hold and lamp done");
    // clear on error, high speed, eight points, lamp disabled
    do_reset(4'b1101, 8'(FH / 20), 5'h08);
    w = 16'($urandom) | 16'hFF00;
    exp_in.push_back(w & MASK_8);
    u_rio_remote.send(w, 1'b0);
    repeat (5) @(posedge mclk);
    check("in_taken_hs", 16'(exp_in.size()), 16'h0000);
    bad_frame(16'h0000, 2'b00);
    // eight point output frame at high speed; an odd upper byte must not reach the parity
    repeat (2) @(posedge tx_stb);
    w = (16'($urandom) & MASK_8) | 16'h8000;
    push(w);
    out_valid <= 1'b0;
    for (int i = 0; i < 1000 && exp_tx.size() > 0; i++) @(posedge mclk);
    check("tx_sent_hs", 16'(exp_tx.size()), 16'h0000);
    $display("test clear and high speed done");
    end_sim();
  end
endmodule
